// ===== hdl/cke_pkg.sv
package cke_pkg;
  // Link-clock counts (memory clock edges)
  localparam int unsigned CKE_MIN_PULSE = 3;
  localparam int unsigned SR_READ_CLOCKS = 200;
  localparam int unsigned PD_EXIT_CLOCKS = 2;
  localparam int unsigned FAST_EXIT_READ_CLOCKS = 2;
  localparam int unsigned SLOW_EXIT_READ_CLOCKS = 6;
  localparam int unsigned MODE_SET_CLOCKS = 2;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ERR = 8'h08;
  localparam logic [7:0] REG_MODE = 8'h0c;
  localparam logic [7:0] REG_EXT = 8'h10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int unsigned STATUS_BANK_LSB = 8;
  // Mode field positions
  localparam int unsigned MODE_BL_LSB = 0;
  localparam int unsigned MODE_CL_LSB = 4;
  localparam int unsigned MODE_WR_LSB = 9;
  localparam int unsigned MODE_SLOW_EXIT_BIT = 12;
  localparam int unsigned EXT_AL_LSB = 3;
  localparam int unsigned EXT_RTT0_BIT = 2;
  localparam int unsigned EXT_RTT1_BIT = 6;
  localparam logic [2:0] BL4_CODE = 3'h2;
  // Error flag positions
  localparam int unsigned ERR_ILLEGAL = 0;
  localparam int unsigned ERR_PULSE = 1;
  localparam int unsigned ERR_BUSY_ENTRY = 2;
  localparam int unsigned ERR_EXIT_TIMING = 3;
  typedef enum logic [1:0] {
    ST_NORMAL, ST_ACT_PD, ST_PRE_PD, ST_SELF_REF
  } power_state_t;
  typedef enum logic [3:0] {
    CMD_DESEL, CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE,
    CMD_PRE, CMD_REF, CMD_LM, CMD_RSVD
  } cmd_t;
endpackage : cke_pkg

// ===== hdl/cke_if.sv
`timescale 1ns/1ps
interface link_sample_if;
  logic tick;
  logic cke;
  logic cs_n;
  logic [2:0] rcw_n;
  logic [2:0] bank;
  logic [13:0] addr;
  logic on_die_termination;
  modport src (output tick, cke, cs_n, rcw_n, bank, addr, on_die_termination);
  modport dst (input tick, cke, cs_n, rcw_n, bank, addr, on_die_termination);
endinterface : link_sample_if

interface regs_if;
  logic enable;
  logic [3:0] err_clr;
  logic [3:0] err;
  logic [1:0] state;
  logic [7:0] banks;
  logic [13:0] mode_cfg;
  logic [13:0] ext_cfg;
  modport regs (output enable, err_clr, input err, state, banks, mode_cfg, ext_cfg);
  modport core (input enable, err_clr, output err, state, banks, mode_cfg, ext_cfg);
endinterface : regs_if

// ===== hdl/link_sampler.sv
`timescale 1ns/1ps
module link_sampler (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [23:0] pins_in,
  link_sample_if.src lk
);
  logic [23:0] s1_q;
  logic [23:0] s2_q;
  logic ck_d_q;

  // Pins are asynchronous to the system clock
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s1_q <= '0;
      s2_q <= '0;
      ck_d_q <= 1'b0;
    end else if (ce_in) begin
      s1_q <= pins_in;
      s2_q <= s1_q;
      ck_d_q <= s2_q[23];
    end
  end

  // Sample everything on the memory clock rising edge
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      lk.tick <= 1'b0;
      lk.cke <= 1'b0;
      lk.cs_n <= 1'b1;
      lk.rcw_n <= 3'h7;
      lk.bank <= '0;
      lk.addr <= '0;
      lk.on_die_termination <= 1'b0;
    end else if (ce_in) begin
      lk.tick <= s2_q[23] & ~ck_d_q;
      if (s2_q[23] & ~ck_d_q) begin
        lk.cke <= s2_q[22];
        lk.cs_n <= s2_q[21];
        lk.rcw_n <= s2_q[20:18];
        lk.bank <= s2_q[17:15];
        lk.addr <= s2_q[14:1];
        lk.on_die_termination <= s2_q[0];
      end
    end
  end

  // A frozen tick may stand while ce_in is low
  property p_tick_pulse;
    @(posedge sys_clk_in) disable iff (reset_in)
    ce_in && lk.tick |=> !(ce_in && lk.tick);
  endproperty
  // one decision per memory clock edge
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("edge tick longer than one cycle");
endmodule : link_sampler

// ===== hdl/wb_regs.sv
`timescale 1ns/1ps
module wb_regs
  import cke_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  regs_if.regs rg
);
  logic ctrl_q;
  logic req;
  logic wr_now;

  assign req = wb_cyc_in & wb_stb_in;
  // Write lands on the edge at which the master sees ack
  assign wr_now = req & wb_we_in & wb_ack_out & wb_sel_in[0];
  assign rg.enable = ctrl_q;
  assign rg.err_clr = (wr_now && wb_adr_in == REG_ERR) ? wb_dat_in[3:0] : 4'h0;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      wb_ack_out <= 1'b0;
    end else if (ce_in) begin
      wb_ack_out <= req & ~wb_ack_out;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ctrl_q <= CTRL_RST[0];
    end else if (ce_in && wr_now && wb_adr_in == REG_CTRL) begin
      ctrl_q <= wb_dat_in[0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      wb_dat_out <= '0;
    end else if (ce_in && req && !wb_ack_out) begin
      unique case (wb_adr_in)
        REG_CTRL: wb_dat_out <= {31'h0, ctrl_q};
        REG_STATUS: wb_dat_out <= {16'h0, rg.banks, 6'h0, rg.state};
        REG_ERR: wb_dat_out <= {28'h0, rg.err};
        REG_MODE: wb_dat_out <= {18'h0, rg.mode_cfg};
        REG_EXT: wb_dat_out <= {18'h0, rg.ext_cfg};
        default: wb_dat_out <= '0;
      endcase
    end
  end

  property p_ack_once;
    @(posedge sys_clk_in) disable iff (reset_in)
    ce_in && wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held two cycles");
endmodule : wb_regs

// ===== hdl/sdram_cke_power_state_control.sv
`timescale 1ns/1ps
// Summary of operation
// - Each clock edge acts on clock enable now, before, state and command.
// - Unlisted combinations are illegal; device flags them, behaviour undefined.
// - Low-low holds power-down or self refresh, commands ignored.
// - Power-down entry and exit only with NOP or deselect.
// - High-low with NOP: active power-down if a bank open, else precharge.
// - Refresh with high-low enters self refresh, only with all banks idle.
// - No refresh runs during power-down; controller bounds the stay.
// - Termination never affects transitions; unavailable in self refresh.
// - Write with auto precharge: entry one clock after recovery expires.
// - Precharge power-down allowed one clock after refresh.
// - Active power-down allowed one clock after activate.
// - Precharge power-down allowed one clock after precharge.
// - Active exit to read: fast delay if mode bit 12 clear, else slow.
// - Clock align loop frozen in precharge power-down; key buffers stay on (here input_buffers_on_out is low in every state but normal).
module sdram_cke_power_state_control
  import cke_pkg::*;
#(
  parameter int unsigned SR_NONREAD_CLOCKS = 20,
  parameter int unsigned SLOW_EXIT_CLOCKS = SLOW_EXIT_READ_CLOCKS
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic mem_clk_in,
  input wire logic clock_gate_in,
  input wire logic chip_sel_n_in,
  input wire logic row_strobe_n_in,
  input wire logic col_strobe_n_in,
  input wire logic write_en_n_in,
  input wire logic [2:0] bank_in,
  input wire logic [13:0] addr_in,
  input wire logic on_die_termination_in,
  output logic [1:0] power_state_out,
  output logic clock_align_frozen_out,
  output logic input_buffers_on_out,
  output logic termination_on_out,
  output logic self_refresh_running_out
);
  link_sample_if lk ();
  regs_if rg ();

  power_state_t state_q;
  logic cke_prev_q;
  logic [1:0] hold_q;
  logic [7:0] banks_q;
  logic [3:0] err_q;
  logic [3:0] err_set;
  logic [13:0] mode_q;
  logic [13:0] ext_q;
  logic [5:0] busy_q;
  logic [7:0] since_exit_q;
  logic [7:0] read_wait_q;
  logic [7:0] nonread_wait_q;
  cmd_t cmd;
  logic step;
  logic nop_like;
  logic go_low;
  logic go_high;
  logic [2:0] cl;
  logic [2:0] al;
  logic [3:0] wr;
  logic [3:0] half_burst;
  logic [5:0] rd_busy;
  logic [5:0] wr_busy;

  link_sampler u_sampler (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .pins_in({mem_clk_in, clock_gate_in, chip_sel_n_in, row_strobe_n_in,
              col_strobe_n_in, write_en_n_in, bank_in, addr_in,
              on_die_termination_in}),
    .lk(lk.src)
  );

  wb_regs u_regs (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out),
    .rg(rg.regs)
  );

  assign rg.err = err_q;
  assign rg.state = state_q;
  assign rg.banks = banks_q;
  assign rg.mode_cfg = mode_q;
  assign rg.ext_cfg = ext_q;

  // Command decode from the registered pins
  always_comb begin
    if (lk.cs_n) begin
      cmd = CMD_DESEL;
    end else begin
      unique case (lk.rcw_n)
        3'h7: cmd = CMD_NOP;
        3'h3: cmd = CMD_ACT;
        3'h5: cmd = CMD_READ;
        3'h4: cmd = CMD_WRITE;
        3'h2: cmd = CMD_PRE;
        3'h1: cmd = CMD_REF;
        3'h0: cmd = CMD_LM;
        default: cmd = CMD_RSVD;
      endcase
    end
  end

  // act only on memory edges while enabled
  assign step = ce_in & lk.tick & rg.enable;
  assign nop_like = (cmd == CMD_NOP) || (cmd == CMD_DESEL);
  assign go_low = cke_prev_q & ~lk.cke;
  assign go_high = ~cke_prev_q & lk.cke;

  // Latencies from the loaded mode words
  assign cl = mode_q[MODE_CL_LSB +: 3];
  assign al = ext_q[EXT_AL_LSB +: 3];
  // recovery field sets auto precharge point
  assign wr = {1'b0, mode_q[MODE_WR_LSB +: 3]} + 4'h1;
  assign half_burst = (mode_q[MODE_BL_LSB +: 3] == BL4_CODE) ? 4'h2 : 4'h4;
  // read busy until the burst completes
  assign rd_busy = 6'({3'h0, cl} + {3'h0, al} + {2'h0, half_burst});
  // write busy through recovery, entry one clock later
  assign wr_busy = 6'({3'h0, cl} + {3'h0, al} + {2'h0, half_burst} + {2'h0, wr});

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cke_prev_q <= 1'b0;
    end else if (step) begin
      cke_prev_q <= lk.cke;
    end
  end

  // count registrations of the current level
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      hold_q <= 2'h3;
    end else if (step) begin
      if (lk.cke != cke_prev_q) begin
        hold_q <= 2'h1;
      end else if (hold_q != 2'h3) begin
        hold_q <= hold_q + 2'h1;
      end
    end
  end

  // Power state machine
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_q <= ST_NORMAL;
    end else if (step) begin
      unique case (state_q)
        ST_NORMAL: begin
          if (go_low && nop_like) begin
            // bank state picks the power-down kind
            state_q <= (banks_q != 8'h0) ? ST_ACT_PD : ST_PRE_PD;
          end else if (go_low && cmd == CMD_REF && banks_q == 8'h0) begin
            // self refresh only from all idle
            state_q <= ST_SELF_REF;
          end
        end
        ST_ACT_PD, ST_PRE_PD, ST_SELF_REF: begin
          // low-low holds; commands not looked at
          // raising edge leaves the low-power state
          if (go_high) begin
            state_q <= ST_NORMAL;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      banks_q <= 8'h0;
    end else if (step && state_q == ST_NORMAL && cke_prev_q && lk.cke) begin
      unique case (cmd)
        CMD_ACT: banks_q[lk.bank] <= 1'b1;
        CMD_PRE: begin
          if (lk.addr[10]) begin
            banks_q <= 8'h0;
          end else begin
            banks_q[lk.bank] <= 1'b0;
          end
        end
        // Auto precharge closes the row at issue; entry kind stays right
        CMD_READ, CMD_WRITE: begin
          if (lk.addr[10]) begin
            banks_q[lk.bank] <= 1'b0;
          end
        end
        default: banks_q <= banks_q;
      endcase
    end
  end

  // Mode loads and access busy tracking
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      mode_q <= '0;
      ext_q <= '0;
      busy_q <= '0;
    end else if (step) begin
      if (state_q == ST_NORMAL && cke_prev_q && lk.cke && cmd == CMD_LM) begin
        if (lk.bank == 3'h0) begin
          mode_q <= lk.addr;
        end else if (lk.bank == 3'h1) begin
          ext_q <= lk.addr;
        end
        // entry blocked until mode set delay
        busy_q <= 6'(MODE_SET_CLOCKS);
      end else if (state_q == ST_NORMAL && cke_prev_q && lk.cke
                   && cmd == CMD_READ) begin
        busy_q <= rd_busy;
      end else if (state_q == ST_NORMAL && cke_prev_q && lk.cke
                   && cmd == CMD_WRITE) begin
        busy_q <= wr_busy;
      end else if (busy_q != 6'h0) begin
        // refresh, activate, precharge set no busy
        busy_q <= busy_q - 6'h1;
      end
    end
  end

  // Exit windows measured in memory clocks
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      since_exit_q <= 8'hff;
      read_wait_q <= '0;
      nonread_wait_q <= '0;
    end else if (step) begin
      if (state_q != ST_NORMAL && go_high) begin
        since_exit_q <= 8'h0;
        if (state_q == ST_SELF_REF) begin
          read_wait_q <= 8'(SR_READ_CLOCKS);
          nonread_wait_q <= 8'(SR_NONREAD_CLOCKS);
        end else begin
          nonread_wait_q <= 8'(PD_EXIT_CLOCKS);
          if (state_q == ST_ACT_PD && !mode_q[MODE_SLOW_EXIT_BIT]) begin
            read_wait_q <= 8'(FAST_EXIT_READ_CLOCKS);
          end else if (state_q == ST_ACT_PD) begin
            read_wait_q <= 8'(SLOW_EXIT_CLOCKS) - {5'h0, al};
          end else begin
            read_wait_q <= 8'(PD_EXIT_CLOCKS);
          end
        end
      end else if (since_exit_q != 8'hff) begin
        since_exit_q <= since_exit_q + 8'h1;
      end
    end
  end

  // Error sources, each a misuse by the controller
  always_comb begin
    err_set = 4'h0;
    if (step) begin
      if (lk.cke != cke_prev_q && hold_q < 2'(CKE_MIN_PULSE)) begin
        err_set[ERR_PULSE] = 1'b1;
      end
      if (state_q == ST_NORMAL && go_low) begin
        // entry only with NOP or deselect
        // refresh entry with an open bank
        if (!nop_like && !(cmd == CMD_REF && banks_q == 8'h0)) begin
          err_set[ERR_ILLEGAL] = 1'b1;
        end
        if (busy_q != 6'h0) begin
          err_set[ERR_BUSY_ENTRY] = 1'b1;
        end
      end
      if (state_q != ST_NORMAL && go_high && !nop_like) begin
        err_set[ERR_ILLEGAL] = 1'b1;
      end
      if (state_q == ST_NORMAL && cke_prev_q && lk.cke) begin
        if (cmd == CMD_RSVD) begin
          err_set[ERR_ILLEGAL] = 1'b1;
        end
        if (cmd == CMD_READ && since_exit_q < read_wait_q) begin
          err_set[ERR_EXIT_TIMING] = 1'b1;
        end
        if (!nop_like && cmd != CMD_READ && since_exit_q < nonread_wait_q) begin
          err_set[ERR_EXIT_TIMING] = 1'b1;
        end
      end
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      err_q <= 4'h0;
    end else if (ce_in) begin
      err_q <= (err_q & ~rg.err_clr) | err_set;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      power_state_out <= ST_NORMAL;
      clock_align_frozen_out <= 1'b0;
      input_buffers_on_out <= 1'b1;
      termination_on_out <= 1'b0;
      self_refresh_running_out <= 1'b0;
    end else if (ce_in) begin
      power_state_out <= state_q;
      // loop frozen only in precharge power-down
      clock_align_frozen_out <= (state_q == ST_PRE_PD);
      // Input buffers are on only in the normal state and off in every power-down and self refresh state
      input_buffers_on_out <= (state_q == ST_NORMAL);
      // termination never steers state; off in self refresh
      termination_on_out <= lk.on_die_termination && (state_q != ST_SELF_REF)
                            && (ext_q[EXT_RTT0_BIT] || ext_q[EXT_RTT1_BIT]);
      // internal refresh only in self refresh
      self_refresh_running_out <= (state_q == ST_SELF_REF);
    end
  end

  property p_sr_entry;
    @(posedge sys_clk_in) disable iff (reset_in)
    step && state_q == ST_NORMAL && go_low && cmd == CMD_REF && banks_q == 8'h0
    |=> state_q == ST_SELF_REF ##2 self_refresh_running_out;
  endproperty
  a_sr_entry: assert property (p_sr_entry)
    else $error("self refresh not entered");

  property p_pd_kind;
    @(posedge sys_clk_in) disable iff (reset_in)
    step && state_q == ST_NORMAL && go_low && nop_like
    |=> state_q == ((banks_q != 8'h0) ? ST_ACT_PD : ST_PRE_PD);
  endproperty
  a_pd_kind: assert property (p_pd_kind)
    else $error("wrong power-down kind");

  property p_low_hold;
    @(posedge sys_clk_in) disable iff (reset_in)
    step && state_q != ST_NORMAL && !cke_prev_q && !lk.cke
    |=> $stable(state_q) && $stable(banks_q);
  endproperty
  a_low_hold: assert property (p_low_hold)
    else $error("state moved while clock enable low");

  property p_exit_cmd;
    @(posedge sys_clk_in) disable iff (reset_in)
    step && state_q != ST_NORMAL && go_high && !nop_like
    |=> err_q[ERR_ILLEGAL];
  endproperty
  a_exit_cmd: assert property (p_exit_cmd)
    else $error("bad exit command not flagged");

  property p_pulse;
    @(posedge sys_clk_in) disable iff (reset_in)
    step && lk.cke != cke_prev_q && hold_q == 2'h1 |=> err_q[ERR_PULSE];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("short clock enable pulse not flagged");

  property p_sr_no_term;
    @(posedge sys_clk_in) disable iff (reset_in)
    ce_in && state_q == ST_SELF_REF |=> !termination_on_out;
  endproperty
  a_sr_no_term: assert property (p_sr_no_term)
    else $error("termination on in self refresh");

  property p_frozen;
    @(posedge sys_clk_in) disable iff (reset_in)
    ce_in && $rose(state_q == ST_PRE_PD) |-> ##1 clock_align_frozen_out;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("loop not frozen in precharge power-down");

  property p_sticky;
    @(posedge sys_clk_in) disable iff (reset_in)
    ce_in && err_q[ERR_ILLEGAL] && !rg.err_clr[ERR_ILLEGAL]
    |=> err_q[ERR_ILLEGAL];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error flag lost");

  property p_sr_read_wait;
    @(posedge sys_clk_in) disable iff (reset_in)
    step && state_q == ST_SELF_REF && go_high
    |=> read_wait_q == 8'd200 && since_exit_q == 8'h0;
  endproperty
  a_sr_read_wait: assert property (p_sr_read_wait)
    else $error("self refresh read window wrong");

  property p_no_busy_cmds;
    @(posedge sys_clk_in) disable iff (reset_in)
    step && state_q == ST_NORMAL && cke_prev_q && lk.cke && busy_q == 6'h0
    && (cmd == CMD_ACT || cmd == CMD_PRE || cmd == CMD_REF)
    |=> busy_q == 6'h0;
  endproperty
  a_no_busy_cmds: assert property (p_no_busy_cmds)
    else $error("row command blocked power-down entry");
endmodule : sdram_cke_power_state_control

// ===== verification/mem_ctrl_model.sv
`timescale 1ns/1ps
module mem_ctrl_model (
  input wire logic cke_in,
  input wire logic [3:0] cmd_in,
  input wire logic [2:0] bank_in,
  input wire logic [13:0] addr_in,
  input wire logic term_in,
  output logic clk_out,
  output logic cke_out,
  output logic [3:0] cmd_n_out,
  output logic [2:0] bank_out,
  output logic [13:0] addr_out,
  output logic term_out
);
  initial begin
    clk_out = 1'b0;
    forever #100 clk_out = ~clk_out;
  end
  initial begin
    {cke_out, cmd_n_out, bank_out, addr_out, term_out} = {1'b0, 4'hf, 17'h0, 1'b0};
    forever @(negedge clk_out) begin
      cke_out <= cke_in;
      cmd_n_out <= cmd_in;
      bank_out <= bank_in;
      addr_out <= addr_in;
      term_out <= term_in;
    end
  end
endmodule : mem_ctrl_model

// ===== verification/sdram_cke_power_state_control_test.sv
`timescale 1ns/1ps
`define CHK(x, y) begin num_checks++; if ((x) !== (y)) begin err_count++; $display("Error %0t: got %h want %h", $time, x, y); end end
module sdram_cke_power_state_control_test;
  import cke_pkg::*;
  localparam logic [3:0] C_NOP = 4'h7;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_MODE = 4'h0;
  logic sys_clk = 1'b0;
  logic ce = 1'b1;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic cke_r = 1'b0;
  logic [3:0] cmd_r = 4'hf;
  logic [2:0] bank_r = 3'h0;
  logic [13:0] addr_r = 14'h0;
  logic term_r = 1'b0;
  logic mclk, cke, term, frozen, bufs_on, term_on, sr_on;
  logic [3:0] cmd_n;
  logic [2:0] bank;
  logic [13:0] addr;
  logic [1:0] pstate;
  int err_count = 0;
  int num_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  mem_ctrl_model i_ctrl (.cke_in(cke_r), .cmd_in(cmd_r), .bank_in(bank_r),
    .addr_in(addr_r), .term_in(term_r), .clk_out(mclk), .cke_out(cke),
    .cmd_n_out(cmd_n), .bank_out(bank), .addr_out(addr), .term_out(term));
  sdram_cke_power_state_control i_dut (.sys_clk_in(sys_clk), .reset_in(reset),
    .ce_in(ce), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat), .wb_dat_out(wb_rdat),
    .wb_ack_out(wb_ack), .mem_clk_in(mclk), .clock_gate_in(cke),
    .chip_sel_n_in(cmd_n[3]), .row_strobe_n_in(cmd_n[2]),
    .col_strobe_n_in(cmd_n[1]), .write_en_n_in(cmd_n[0]), .bank_in(bank),
    .addr_in(addr), .on_die_termination_in(term), .power_state_out(pstate),
    .clock_align_frozen_out(frozen), .input_buffers_on_out(bufs_on),
    .termination_on_out(term_on), .self_refresh_running_out(sr_on));
  function automatic logic [1:0] pd_kind(input logic open);
    return open ? ST_ACT_PD : ST_PRE_PD;
  endfunction : pd_kind
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // Ack and read data taken at the edge that sees ack; watchdog ends a hang
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    cyc <= 1'b0;
  endtask : wb
  task automatic step(input logic c, input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      cke_r <= c;
      cmd_r <= m;
      @(negedge mclk);
      @(posedge mclk);
      @(posedge sys_clk);
      cmd_r <= C_NOP;
    end
    // Outputs trail the memory edge by a few cycles
    repeat (8) @(posedge sys_clk);
  endtask : step
  initial begin
    #2_000_000;
    err_count++;
    report_and_stop();
  end
  initial begin
    int bk;
    void'($urandom(32'hc951));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    wb(1'b0, REG_CTRL, 32'h0);
    `CHK(rd, CTRL_RST)
    wb(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(bufs_on, 1'b1)
    step(1'b1, C_NOP, 4);
    bank_r <= 3'h1;
    addr_r <= 14'h0004;
    step(1'b1, C_MODE, 1);
    bank_r <= 3'h0;
    addr_r <= 14'h0600;
    step(1'b1, C_MODE, 1);
    step(1'b1, C_NOP, 3);
    wb(1'b0, REG_EXT, 32'h0);
    `CHK(rd[13:0], 14'h0004)
    wb(1'b0, REG_MODE, 32'h0);
    `CHK(rd[MODE_WR_LSB +: 3], 3'h3)
    term_r <= 1'b1;
    step(1'b1, C_NOP, 1);
    `CHK(term_on, 1'b1)
    bk = $urandom_range(7);
    for (int i = 0; i < 2; i++) begin
      bank_r <= bk[2:0];
      addr_r <= i[0] ? 14'h0 : 14'h0400;
      term_r <= 1'($urandom);
      step(1'b1, i[0] ? C_ACT : C_PRE, 1);
      step(1'b0, C_NOP, 3);
      `CHK(pstate, pd_kind(i[0]))
      `CHK(frozen, !i[0])
      `CHK(bufs_on, 1'b0)
      // Low enable must hold the power state through a raised clock gate
      ce <= 1'b0;
      step(1'b1, C_NOP, 2);
      `CHK(pstate, pd_kind(i[0]))
      ce <= 1'b1;
      step(1'b1, C_NOP, 3);
      `CHK(pstate, ST_NORMAL)
    end
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[15:8], 8'h01 << bk)
    step(1'b0, C_REF, 1);
    `CHK(pstate, ST_NORMAL)
    step(1'b0, C_NOP, 2);
    step(1'b1, C_NOP, 3);
    wb(1'b0, REG_ERR, 32'h0);
    `CHK(rd[3:0], 4'h1 << ERR_ILLEGAL)
    wb(1'b1, REG_ERR, 32'hf);
    wb(1'b0, REG_ERR, 32'h0);
    `CHK(rd[3:0], 4'h0)
    addr_r <= 14'h0400;
    term_r <= 1'b1;
    step(1'b1, C_PRE, 1);
    step(1'b1, C_NOP, 2);
    step(1'b0, C_REF, 1);
    step(1'b0, C_NOP, 2);
    `CHK(pstate, ST_SELF_REF)
    `CHK(sr_on, 1'b1)
    `CHK(term_on, 1'b0)
    step(1'b1, C_NOP, 3);
    `CHK(pstate, ST_NORMAL)
    step(1'b1, C_NOP, 20);
    wb(1'b0, REG_ERR, 32'h0);
    `CHK(rd[3:0], 4'h0)
    // Short low level, then exit with a real command
    step(1'b0, C_NOP, 1);
    step(1'b1, C_ACT, 1);
    step(1'b1, C_NOP, 3);
    wb(1'b0, REG_ERR, 32'h0);
    `CHK(rd[ERR_ILLEGAL], 1'b1)
    `CHK(rd[ERR_PULSE], 1'b1)
    report_and_stop();
  end
endmodule : sdram_cke_power_state_control_test
